// ==== inc/otpf_pkg.sv ====
// shared constants, types and register map of the one-time fuse controller
package otpf_pkg;

	// ****************************************************************
	// bus carrier
	// ****************************************************************
	typedef struct packed {
		logic [7:0]  address;                    // byte address
		logic        read;                       // read request
		logic        write;                      // write request
		logic [31:0] writedata;                  // write data
		logic [3:0]  byteenable;                 // byte lanes of a write
	} otpf_avreq_t;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_PGM_DATA  = 8'h00;    // program_data_word 0..7
	localparam logic [7:0] OFS_PGM_CHECK = 8'h20;    // program_check_word 0..2
	localparam logic [7:0] OFS_RD_WDIS   = 8'h2C;    // loaded write_disable_mask
	localparam logic [7:0] OFS_RD_B0     = 8'h30;    // loaded block 0 parameter word
	localparam logic [7:0] OFS_RD_BLK1   = 8'h34;    // block 1 words 0..2
	localparam logic [7:0] OFS_RD_BLK2   = 8'h40;    // block 2 words 0..7
	localparam logic [7:0] OFS_RD_BLK3   = 8'h60;    // block 3 words 0..7
	localparam logic [7:0] OFS_COPY_ERR  = 8'h80;    // block0_copy_error
	localparam logic [7:0] OFS_RS_ERR    = 8'h84;    // rs_decode_error
	localparam logic [7:0] OFS_CONF      = 8'h88;    // operation_config, key in [15:0]
	localparam logic [7:0] OFS_CMD       = 8'h8C;    // command_word
	localparam logic [7:0] OFS_IRQ_RAW   = 8'h90;    // irq_raw_status
	localparam logic [7:0] OFS_IRQ_ENA   = 8'h94;    // irq_enable
	localparam logic [7:0] OFS_IRQ_CLR   = 8'h98;    // irq_clear
	localparam logic [7:0] OFS_BLK_SEL   = 8'h9C;    // block_select in [1:0]

	// ****************************************************************
	// keys, bit positions, reset values
	// ****************************************************************
	localparam logic [15:0] KEY_PGM  = 16'h5A5A;     // operation_key for programming
	localparam logic [15:0] KEY_READ = 16'h5AA5;     // operation_key for read refresh
	localparam int CMD_READ_BIT = 0;                 // read_refresh_command
	localparam int CMD_PGM_BIT  = 1;                 // program_command
	localparam int EVT_READ_BIT = 0;                 // read done event
	localparam int EVT_PGM_BIT  = 1;                 // program_finished event
	localparam int WD_RDDIS = 0;                     // guards read_disable_mask
	localparam int WD_B0    = 1;                     // guards rest of block 0 word
	localparam int WD_BLK1  = 5;                     // guards block 1
	localparam int WD_BLK2  = 6;                     // guards block 2
	localparam int WD_BLK3  = 7;                     // guards block 3
	localparam int RDDIS_LO = 0;                     // read_disable_mask bit for words 0..3
	localparam int RDDIS_HI = 1;                     // read_disable_mask bit for words 4..7
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [1:0]  RST_CMD   = 2'h1;        // refresh runs out of reset
	localparam logic [7:0]  GF_POLY   = 8'h1D;       // x^8+x^4+x^3+x^2+1, top bit implied
	localparam int CW_LAST    = 43;                  // last codeword byte index
	localparam int PAR_BYTES  = 12;                  // parity bytes per codeword
	localparam logic [255:0] BLK1_MASK = {{168{1'b0}}, {88{1'b1}}}; // block 1 payload

	// ****************************************************************
	// operation states
	// ****************************************************************
	typedef enum logic [1:0] {ST_IDLE, ST_PGM, ST_READ, ST_FIN} otpf_state_t;

endpackage : otpf_pkg

// ==== src/otpf_ctrl.sv ====
// one-time fuse controller: fuse array, program, read refresh, check and registers
//
// Functional notes
// R01 - new write mask acts only after refresh
// R02 - protected parameter bits never change
// R03 - only block 3 words hidden when read-disabled
// R04 - block 0: mask once, parameter four copies
// R05 - blocks 1..3 guarded by RS(44,32) code
// R06 - codeword: 32 data then 12 parity
// R07 - full codeword burned, checked on read
// R08 - unused block 1 payload bits are zero
// R09 - one block per program, shared data words
// R10 - block 0 uses data words 0,1 only
// R11 - block 1 uses data 0..2, check 0..2
// R12 - blocks 2,3 use data 0..7, check 0..2
// R13 - software sets select, data, key, command
// R14 - command word clears when operation ends
// R15 - software clears data, refreshes, checks errors
// R16 - rs error nibbles per block 1,2,3
// R17 - software never reprograms burned bits
// R18 - software burns mask with its parameters
// R19 - refresh at reset, shadows hold value
// R20 - software writes read key then command
// R21 - copy error marks disagreeing block 0 bits
// R22 - per block result recorded each refresh
// R23 - command needs key, ignored while busy
// R24 - raw, enable, clear event bits
module otpf_ctrl (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire otpf_pkg::otpf_avreq_t avs_req,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// word address hit at base plus i words
	function automatic logic hit(input logic [5:0] w, input logic [7:0] base, input int i);
		return w == 6'(int'(base[7:2]) + i);
	endfunction : hit

	// byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (be[k]) r[8*k +: 8] = nw[8*k +: 8];
		end
		return r;
	endfunction : merge

	// multiply in GF(2^8) with the block's primitive polynomial
	function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int k = 0; k < 8; k++) begin
			if (b[k]) p = p ^ x;
			x = {x[6:0], 1'b0} ^ (x[7] ? otpf_pkg::GF_POLY : 8'h00); // R05
		end
		return p;
	endfunction : gf_mul

	// ****************************************************************
	// state
	// ****************************************************************
	logic [31:0]           pgm_data_ff  [8];         // program_data_word
	logic [31:0]           nxt_pgm_data [8];
	logic [31:0]           pgm_check_ff [3];         // program_check_word
	logic [31:0]           nxt_pgm_check[3];
	logic [15:0]           key_ff, nxt_key;          // operation_key
	logic [1:0]            blk_sel_ff, nxt_blk_sel;  // block_select
	logic [1:0]            cmd_ff, nxt_cmd;          // command_word
	logic [1:0]            irq_raw_ff, nxt_irq_raw;  // irq_raw_status
	logic [1:0]            irq_ena_ff, nxt_irq_ena;  // irq_enable, no output pin
	otpf_pkg::otpf_state_t state_ff, nxt_state;
	logic [5:0]            cnt_ff, nxt_cnt;          // codeword byte during refresh
	logic [7:0]            syn_ff  [1:3][12];        // running syndromes per block
	logic [7:0]            nxt_syn [1:3][12];
	// fuse array: no reset, burned bits survive rst_n; starts blank
	logic [7:0]            fz_wd_ff = 8'h00;         // write_disable_mask, single copy
	logic [7:0]            nxt_fz_wd;
	logic [31:0]           fz_b0_ff [4] = '{default: 32'h0}; // four hidden copies
	logic [31:0]           nxt_fz_b0[4];
	logic [351:0]          fz_blk_ff [1:3] = '{default: 352'h0}; // codewords
	logic [351:0]          nxt_fz_blk[1:3];
	// shadow read registers
	logic [7:0]            sh_wd_ff, nxt_sh_wd;
	logic [31:0]           sh_b0_ff, nxt_sh_b0;
	logic [255:0]          sh_blk_ff [1:3];
	logic [255:0]          nxt_sh_blk[1:3];
	logic [31:0]           copy_err_ff, nxt_copy_err; // block0_copy_error
	logic [11:0]           rs_err_ff, nxt_rs_err;     // rs_decode_error
	// bus
	logic                  wait_ff, nxt_wait;
	logic [31:0]           rdata_ff, nxt_rdata;
	logic [5:0]            widx;                     // word index of request
	logic                  acc;                      // request taken this cycle, answered in the next
	logic                  wr_go;
	logic                  rd_go;
	logic [31:0]           rd_val;

	assign widx  = avs_req.address[7:2];
	assign acc   = (avs_req.read | avs_req.write) & wait_ff;
	assign wr_go = acc & avs_req.write;
	assign rd_go = acc & avs_req.read;
	assign avs_readdata    = rdata_ff;
	assign avs_waitrequest = wait_ff;

	// ****************************************************************
	// bus slave: one wait cycle, then a one-cycle answer
	// ****************************************************************
	// read mux; unmapped addresses read zero, writes to them are dropped
	always_comb begin
		rd_val = 32'h0;
		for (int i = 0; i < 8; i++) begin
			if (hit(widx, otpf_pkg::OFS_PGM_DATA, i)) rd_val = pgm_data_ff[i];
			if (hit(widx, otpf_pkg::OFS_RD_BLK2, i)) rd_val = sh_blk_ff[2][32*i +: 32];
			// read-disabled words of block 3 read as zero
			if (hit(widx, otpf_pkg::OFS_RD_BLK3, i)) begin
				if (!sh_b0_ff[(i < 4) ? otpf_pkg::RDDIS_LO : otpf_pkg::RDDIS_HI]) begin // R03
					rd_val = sh_blk_ff[3][32*i +: 32];
				end
			end
		end
		for (int i = 0; i < 3; i++) begin
			if (hit(widx, otpf_pkg::OFS_PGM_CHECK, i)) rd_val = pgm_check_ff[i];
			if (hit(widx, otpf_pkg::OFS_RD_BLK1, i)) rd_val = sh_blk_ff[1][32*i +: 32];
		end
		if (hit(widx, otpf_pkg::OFS_RD_WDIS, 0)) rd_val = {24'h0, sh_wd_ff};
		if (hit(widx, otpf_pkg::OFS_RD_B0, 0)) rd_val = sh_b0_ff;
		if (hit(widx, otpf_pkg::OFS_COPY_ERR, 0)) rd_val = copy_err_ff;
		if (hit(widx, otpf_pkg::OFS_RS_ERR, 0)) rd_val = {20'h0, rs_err_ff};
		if (hit(widx, otpf_pkg::OFS_CONF, 0)) rd_val = {16'h0, key_ff};
		if (hit(widx, otpf_pkg::OFS_CMD, 0)) rd_val = {30'h0, cmd_ff};
		if (hit(widx, otpf_pkg::OFS_IRQ_RAW, 0)) rd_val = {30'h0, irq_raw_ff};
		if (hit(widx, otpf_pkg::OFS_IRQ_ENA, 0)) rd_val = {30'h0, irq_ena_ff};
		if (hit(widx, otpf_pkg::OFS_BLK_SEL, 0)) rd_val = {30'h0, blk_sel_ff};
		nxt_wait  = ~acc;                            // low for exactly one cycle
		nxt_rdata = rd_go ? rd_val : rdata_ff;       // held until next read
	end

	// bus registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wait_ff  <= 1'b1;
			rdata_ff <= otpf_pkg::RST_WORD;
		end else begin
			wait_ff  <= nxt_wait;
			rdata_ff <= nxt_rdata;
		end
	end

	// ****************************************************************
	// control, fuse burning and read refresh
	// ****************************************************************
	always_comb begin
		logic [31:0]  m0;                            // block 0 word burn mask
		logic [351:0] cw;                            // codeword to burn
		logic [255:0] dat;                           // payload of all data words
		logic [7:0]   pw;                            // alpha^j
		logic [1:0]   evt;                           // completion events
		logic [31:0]  b0_or;
		logic [31:0]  b0_and;
		m0     = 32'h0;
		cw     = 352'h0;
		dat    = 256'h0;
		pw     = 8'h01;
		evt    = 2'b00;
		b0_or  = 32'h0;
		b0_and = 32'h0;
		nxt_pgm_data  = pgm_data_ff;
		nxt_pgm_check = pgm_check_ff;
		nxt_key       = key_ff;
		nxt_blk_sel   = blk_sel_ff;
		nxt_cmd       = cmd_ff;
		nxt_irq_ena   = irq_ena_ff;
		nxt_state     = state_ff;
		nxt_cnt       = cnt_ff;
		nxt_syn       = syn_ff;
		nxt_fz_wd     = fz_wd_ff;
		nxt_fz_b0     = fz_b0_ff;
		nxt_fz_blk    = fz_blk_ff;
		nxt_sh_wd     = sh_wd_ff;
		nxt_sh_b0     = sh_b0_ff;
		nxt_sh_blk    = sh_blk_ff;
		nxt_copy_err  = copy_err_ff;
		nxt_rs_err    = rs_err_ff;
		// software writes to plain registers
		for (int i = 0; i < 8; i++) begin
			if (wr_go && hit(widx, otpf_pkg::OFS_PGM_DATA, i)) begin
				nxt_pgm_data[i] = merge(pgm_data_ff[i], avs_req.writedata, avs_req.byteenable);
			end
		end
		for (int i = 0; i < 3; i++) begin
			if (wr_go && hit(widx, otpf_pkg::OFS_PGM_CHECK, i)) begin
				nxt_pgm_check[i] = merge(pgm_check_ff[i], avs_req.writedata,
					avs_req.byteenable);
			end
		end
		if (wr_go && hit(widx, otpf_pkg::OFS_CONF, 0)) begin
			nxt_key = 16'(merge({16'h0, key_ff}, avs_req.writedata, avs_req.byteenable));
		end
		if (wr_go && hit(widx, otpf_pkg::OFS_BLK_SEL, 0) && avs_req.byteenable[0]) begin
			nxt_blk_sel = avs_req.writedata[1:0];
		end
		if (wr_go && hit(widx, otpf_pkg::OFS_IRQ_ENA, 0) && avs_req.byteenable[0]) begin
			nxt_irq_ena = avs_req.writedata[1:0];            // R24
		end
		// command: needs the matching key, dropped unless idle
		if (wr_go && hit(widx, otpf_pkg::OFS_CMD, 0) && avs_req.byteenable[0]
				&& state_ff == otpf_pkg::ST_IDLE) begin  // R23
			if (avs_req.writedata[otpf_pkg::CMD_PGM_BIT] && key_ff == otpf_pkg::KEY_PGM) begin
				nxt_cmd   = 2'b10;
				nxt_state = otpf_pkg::ST_PGM;
			end else if (avs_req.writedata[otpf_pkg::CMD_READ_BIT]
					&& key_ff == otpf_pkg::KEY_READ) begin // R23
				nxt_cmd   = 2'b01;
				nxt_state = otpf_pkg::ST_READ;
				nxt_cnt   = 6'h00;
				nxt_syn   = '{default: 8'h00};
			end
		end
		for (int i = 0; i < 8; i++) begin
			dat[32*i +: 32] = pgm_data_ff[i];
		end
		case (state_ff)
			// burn the selected block only; masks come from the loaded shadow
			otpf_pkg::ST_PGM: begin
				case (blk_sel_ff) // R09
					2'd0: begin // R10
						nxt_fz_wd = fz_wd_ff | pgm_data_ff[0][7:0]; // R04
						m0 = pgm_data_ff[1];
						if (sh_wd_ff[otpf_pkg::WD_RDDIS]) m0[1:0] = 2'b00;    // R01 R02
						if (sh_wd_ff[otpf_pkg::WD_B0]) m0[31:2] = 30'h0;      // R02
						for (int c = 0; c < 4; c++) begin
							nxt_fz_b0[c] = fz_b0_ff[c] | m0;                   // R04
						end
					end
					2'd1: begin // R11
						cw = {pgm_check_ff[2], pgm_check_ff[1], pgm_check_ff[0],
							dat & otpf_pkg::BLK1_MASK};                         // R06 R08
						if (!sh_wd_ff[otpf_pkg::WD_BLK1]) nxt_fz_blk[1] = fz_blk_ff[1] | cw; // R07
					end
					default: begin // R12
						cw = {pgm_check_ff[2], pgm_check_ff[1], pgm_check_ff[0], dat}; // R06
						if (blk_sel_ff == 2'd2 && !sh_wd_ff[otpf_pkg::WD_BLK2]) begin
							nxt_fz_blk[2] = fz_blk_ff[2] | cw;                 // R02 R07
						end
						if (blk_sel_ff == 2'd3 && !sh_wd_ff[otpf_pkg::WD_BLK3]) begin
							nxt_fz_blk[3] = fz_blk_ff[3] | cw;                 // R02 R07
						end
					end
				endcase
				nxt_cmd = 2'b00;                                           // R14
				evt[otpf_pkg::EVT_PGM_BIT] = 1'b1;
				nxt_state = otpf_pkg::ST_IDLE;
			end
			// one codeword byte per cycle into all syndromes of all blocks
			otpf_pkg::ST_READ: begin
				for (int j = 0; j < otpf_pkg::PAR_BYTES; j++) begin
					for (int b = 1; b <= 3; b++) begin
						nxt_syn[b][j] = gf_mul(syn_ff[b][j], pw)
							^ fz_blk_ff[b][8*cnt_ff +: 8];                     // R05 R07
					end
					pw = gf_mul(pw, 8'h02);
				end
				nxt_cnt = cnt_ff + 6'h01;
				if (cnt_ff == 6'(otpf_pkg::CW_LAST)) nxt_state = otpf_pkg::ST_FIN;
			end
			// load shadows and results in one step
			otpf_pkg::ST_FIN: begin
				b0_or  = fz_b0_ff[0] | fz_b0_ff[1] | fz_b0_ff[2] | fz_b0_ff[3];
				b0_and = fz_b0_ff[0] & fz_b0_ff[1] & fz_b0_ff[2] & fz_b0_ff[3];
				nxt_sh_wd    = fz_wd_ff;                                   // R01
				nxt_sh_b0    = b0_or;
				nxt_copy_err = b0_or & ~b0_and;                            // R21
				for (int b = 1; b <= 3; b++) begin
					nxt_sh_blk[b] = fz_blk_ff[b][255:0];                   // R19
					// fail flag only; the corrected count stays zero
					nxt_rs_err[4*(b-1) +: 4] = 4'h0;                       // R16 R22
					for (int j = 0; j < otpf_pkg::PAR_BYTES; j++) begin
						nxt_rs_err[4*(b-1) + 3] |= (syn_ff[b][j] != 8'h00); // R22
					end
				end
				nxt_cmd = 2'b00;                                           // R14
				evt[otpf_pkg::EVT_READ_BIT] = 1'b1;
				nxt_state = otpf_pkg::ST_IDLE;
			end
			otpf_pkg::ST_IDLE: begin
				nxt_cnt = cnt_ff;
			end
			default: begin
				nxt_state = otpf_pkg::ST_IDLE;
			end
		endcase
		// an event in the clear cycle stays set
		nxt_irq_raw = irq_raw_ff;
		if (wr_go && hit(widx, otpf_pkg::OFS_IRQ_CLR, 0) && avs_req.byteenable[0]) begin
			nxt_irq_raw = irq_raw_ff & ~avs_req.writedata[1:0];    // R24
		end
		nxt_irq_raw = nxt_irq_raw | evt;                           // R24
	end

	// fuse cells: never reset, only ever gain ones
	always_ff @(posedge clk_sys) begin
		fz_wd_ff  <= nxt_fz_wd;
		fz_b0_ff  <= nxt_fz_b0;
		fz_blk_ff <= nxt_fz_blk;
	end

	// control registers; reset starts a refresh
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pgm_data_ff  <= '{default: otpf_pkg::RST_WORD};
			pgm_check_ff <= '{default: otpf_pkg::RST_WORD};
			key_ff       <= 16'h0000;
			blk_sel_ff   <= 2'h0;
			cmd_ff       <= otpf_pkg::RST_CMD;
			irq_raw_ff   <= 2'h0;
			irq_ena_ff   <= 2'h0;
			state_ff     <= otpf_pkg::ST_READ;            // R19
			cnt_ff       <= 6'h00;
			syn_ff       <= '{default: 8'h00};
			sh_wd_ff     <= 8'h00;
			sh_b0_ff     <= otpf_pkg::RST_WORD;
			sh_blk_ff    <= '{default: 256'h0};
			copy_err_ff  <= otpf_pkg::RST_WORD;
			rs_err_ff    <= 12'h000;
		end else begin
			pgm_data_ff  <= nxt_pgm_data;
			pgm_check_ff <= nxt_pgm_check;
			key_ff       <= nxt_key;
			blk_sel_ff   <= nxt_blk_sel;
			cmd_ff       <= nxt_cmd;
			irq_raw_ff   <= nxt_irq_raw;
			irq_ena_ff   <= nxt_irq_ena;
			state_ff     <= nxt_state;
			cnt_ff       <= nxt_cnt;
			syn_ff       <= nxt_syn;
			sh_wd_ff     <= nxt_sh_wd;
			sh_b0_ff     <= nxt_sh_b0;
			sh_blk_ff    <= nxt_sh_blk;
			copy_err_ff  <= nxt_copy_err;
			rs_err_ff    <= nxt_rs_err;
		end
	end

endmodule : otpf_ctrl

// ==== test/otpf_ctrl_chk.sv ====
// bus timing and register format checks for the fuse controller, bound to its ports
module otpf_ctrl_chk (
	input wire logic                  clk_sys,         // system clock
	input wire logic                  rst_n,           // synchronous reset, active low
	input wire otpf_pkg::otpf_avreq_t avs_req,         // bus request bundle
	input wire logic [31:0]           avs_readdata,    // read data
	input wire logic                  avs_waitrequest  // answer strobe, active low
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// clocking and sequences
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// a read taken at the given word address
	sequence s_rd_at(logic [7:0] a);
		avs_req.read && avs_waitrequest && (avs_req.address[7:2] == a[7:2]);
	endsequence
	// one low cycle of waitrequest, then high again
	sequence s_pulse;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	// ****************************************************************
	// properties
	// ****************************************************************
	property p_wait_pulse; $fell(avs_waitrequest) |-> s_pulse; endproperty
	property p_answer; (avs_req.read || avs_req.write) && avs_waitrequest |=> s_pulse; endproperty
	property p_cause; $fell(avs_waitrequest) |-> $past(avs_req.read || avs_req.write); endproperty
	// readdata may only move in an answer cycle
	property p_rdata_hold; avs_waitrequest |-> $stable(avs_readdata); endproperty
	property p_unmapped;
		avs_req.read && avs_waitrequest && (avs_req.address >= 8'hA0) |=> avs_readdata == 32'h0;
	endproperty
	property p_rserr_fmt; s_rd_at(8'h84) |=> (avs_readdata & 32'hFFFF_F777) == 32'h0; endproperty
	property p_mask_width; s_rd_at(8'h2C) |=> avs_readdata[31:8] == 24'h0; endproperty
	property p_blk1_top; s_rd_at(8'h3C) |=> avs_readdata[31:24] == 8'h0; endproperty
	property p_evt_width; s_rd_at(8'h90) |=> avs_readdata[31:2] == 30'h0; endproperty
	property p_clr_zero; s_rd_at(8'h98) |=> avs_readdata == 32'h0; endproperty
	property p_cmd_width; s_rd_at(8'h8C) |=> avs_readdata[31:2] == 30'h0; endproperty

	// ****************************************************************
	// assertions
	// ****************************************************************
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
	a_answer: assert property (p_answer) else $error("request not answered next cycle");
	a_cause: assert property (p_cause) else $error("answer without request");
	a_rdata_hold: assert property (p_rdata_hold) else $error("readdata moved outside answer");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_rserr_fmt: assert property (p_rserr_fmt) else $error("rs error field bad");
	a_mask_width: assert property (p_mask_width) else $error("write mask wider than 8");
	a_blk1_top: assert property (p_blk1_top) else $error("block 1 unused bits set");
	a_evt_width: assert property (p_evt_width) else $error("event bits beyond 1:0");
	a_clr_zero: assert property (p_clr_zero) else $error("clear register reads nonzero");
	a_cmd_width: assert property (p_cmd_width) else $error("command bits beyond 1:0");
endmodule : otpf_ctrl_chk

bind otpf_ctrl otpf_ctrl_chk u_otpf_ctrl_chk (
	.clk_sys        (clk_sys),
	.rst_n          (rst_n),
	.avs_req        (avs_req),
	.avs_readdata   (avs_readdata),
	.avs_waitrequest(avs_waitrequest)
);

// ==== test/otpf_ctrl_bench.sv ====
// self-checking bench of the fuse controller over its register bus
module otpf_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// signals and design
	// ****************************************************************
	logic                  clk_sys;      // 20 MHz clock
	logic                  rst_n;        // reset, active low
	otpf_pkg::otpf_avreq_t avs_req;      // bus request
	logic [31:0]           avs_readdata; // read data
	logic                  avs_waitrequest;
	int                    err_count;    // mismatches
	int                    n_compared;   // comparisons made

	otpf_ctrl u_otpf_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .avs_req(avs_req),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// free-running clock, 50 ns period
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// ****************************************************************
	// helper tasks
	// ****************************************************************
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop

	// one bus access; waits for the answer under a bound
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_req <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hF};
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
		if (n >= 50) begin
			$display("MISMATCH waitrequest exp 0 got 1");
			err_count++;
			report_and_stop();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	// read a register and compare it with the expected word
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		n_compared++;
		if (q !== e) begin
			$display("MISMATCH reg %h exp %h got %h", a, e, q);
			err_count++;
		end
	endtask : rd

	// poll command_word until it reads zero, bounded
	task automatic wait_idle;
		logic [31:0] q;
		int          n;
		q = 32'h1;
		for (n = 0; n < 100 && q !== 32'h0; n++) bus(1'b0, otpf_pkg::OFS_CMD, 32'h0, q);
		if (q !== 32'h0) begin
			$display("MISMATCH command_word exp 0 got %h", q);
			err_count++;
			report_and_stop();
		end
	endtask : wait_idle

	// key then command, then wait for the operation to end
	task automatic run(input logic [15:0] key, input logic [31:0] cmd);
		wr(otpf_pkg::OFS_CONF, {16'h0, key});
		wr(otpf_pkg::OFS_CMD, cmd);
		wait_idle();
	endtask : run

	function automatic logic [31:0] pat(input int s, input int i);
		return {s[7:0], i[7:0], 16'hA5C3};
	endfunction : pat

	// ****************************************************************
	// scenarios
	// ****************************************************************
	// reset refresh is running, then ends with read done and blank shadows
	task automatic t_reset;
		rd(otpf_pkg::OFS_CMD, 32'h1);
		wait_idle();
		rd(otpf_pkg::OFS_IRQ_RAW, 32'h1);
		rd(otpf_pkg::OFS_RS_ERR, 32'h0);
		rd(otpf_pkg::OFS_COPY_ERR, 32'h0);
		rd(otpf_pkg::OFS_RD_B0, 32'h0);
		wr(8'hA0, 32'hFFFF_FFFF);
		rd(8'hA0, 32'h0);
	endtask : t_reset

	// event bits, wrong key, command while busy, field widths
	task automatic t_events;
		wr(otpf_pkg::OFS_IRQ_ENA, 32'hFFFF_FFFF);
		rd(otpf_pkg::OFS_IRQ_ENA, 32'h3);
		wr(otpf_pkg::OFS_IRQ_CLR, 32'h3);
		rd(otpf_pkg::OFS_IRQ_RAW, 32'h0);
		rd(otpf_pkg::OFS_IRQ_CLR, 32'h0);
		run(otpf_pkg::KEY_READ, 32'h2);
		rd(otpf_pkg::OFS_IRQ_RAW, 32'h0);
		wr(otpf_pkg::OFS_CONF, {16'h0, otpf_pkg::KEY_READ});
		wr(otpf_pkg::OFS_CMD, 32'h1);
		run(otpf_pkg::KEY_PGM, 32'h2);
		rd(otpf_pkg::OFS_IRQ_RAW, 32'h1);
		wr(otpf_pkg::OFS_BLK_SEL, 32'hFFFF_FFFF);
		rd(otpf_pkg::OFS_BLK_SEL, 32'h3);
		wr(otpf_pkg::OFS_RD_WDIS, 32'hFF);
		rd(otpf_pkg::OFS_RD_WDIS, 32'h0);
		wr(otpf_pkg::OFS_IRQ_CLR, 32'h3);
	endtask : t_events

	// blocks 1 and 3 with zero parity: data raw, fail flag per block
	task automatic t_rs;
		for (int s = 1; s <= 3; s += 2) begin
			for (int i = 0; i < 8; i++) wr(8'(4 * i), pat(s, i));
			for (int j = 0; j < 3; j++) wr(8'(32 + 4 * j), 32'h0);
			wr(otpf_pkg::OFS_BLK_SEL, 32'(s));
			run(otpf_pkg::KEY_PGM, 32'h2);
			rd(otpf_pkg::OFS_IRQ_RAW, 32'h2);
			rd(otpf_pkg::OFS_RD_BLK1, 32'h0);
			wr(otpf_pkg::OFS_IRQ_CLR, 32'h3);
		end
		for (int i = 0; i < 8; i++) wr(8'(4 * i), 32'h0);
		run(otpf_pkg::KEY_READ, 32'h1);
		rd(otpf_pkg::OFS_RD_BLK1, pat(1, 0));
		rd(otpf_pkg::OFS_RD_BLK1 + 8'h4, pat(1, 1));
		rd(otpf_pkg::OFS_RD_BLK1 + 8'h8, pat(1, 2) & 32'h00FF_FFFF);
		for (int i = 0; i < 8; i++) rd(otpf_pkg::OFS_RD_BLK3 + 8'(4 * i), pat(3, i));
		rd(otpf_pkg::OFS_RS_ERR, 32'h0000_0808);
	endtask : t_rs

	// block 0 burn, mask loaded only by refresh, guarded bits kept
	task automatic t_blk0;
		wr(otpf_pkg::OFS_BLK_SEL, 32'h0);
		wr(otpf_pkg::OFS_PGM_DATA, 32'h2);
		wr(otpf_pkg::OFS_PGM_DATA + 8'h4, 32'h1234_5678);
		wr(otpf_pkg::OFS_PGM_CHECK, 32'hFFFF_FFFF);
		run(otpf_pkg::KEY_PGM, 32'h2);
		rd(otpf_pkg::OFS_RD_WDIS, 32'h0);
		run(otpf_pkg::KEY_READ, 32'h1);
		rd(otpf_pkg::OFS_RD_WDIS, 32'h2);
		rd(otpf_pkg::OFS_RD_B0, 32'h1234_5678);
		rd(otpf_pkg::OFS_COPY_ERR, 32'h0);
		wr(otpf_pkg::OFS_PGM_DATA, 32'h0);
		wr(otpf_pkg::OFS_PGM_DATA + 8'h4, 32'hEDCB_A987);
		run(otpf_pkg::KEY_PGM, 32'h2);
		run(otpf_pkg::KEY_READ, 32'h1);
		rd(otpf_pkg::OFS_RD_B0, 32'h1234_567B);
		rd(otpf_pkg::OFS_RD_BLK3, 32'h0);
		rd(otpf_pkg::OFS_RD_BLK3 + 8'h10, 32'h0);
		rd(otpf_pkg::OFS_RD_BLK1, pat(1, 0));
	endtask : t_blk0

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		err_count = 0;
		n_compared = 0;
		rst_n = 1'b0;
		avs_req = '0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_events();
		t_rs();
		t_blk0();
		report_and_stop();
	end
endmodule : otpf_ctrl_bench
